//--- common/vfilt_pkg.sv
package vfilt_pkg;
    // ==========================================================
    // Register map
    localparam logic [6:0] DEC_SEL_ADDR = 7'h46;
    localparam logic [6:0] FILT_CTL_ADDR = 7'h47;
    localparam logic [6:0] RO_LO_ADDR = 7'h19;
    localparam logic [6:0] RO_HI_ADDR = 7'h2c;
    localparam logic [6:0] TEST_LO_ADDR = 7'h1a;
    localparam logic [6:0] TEST_HI_ADDR = 7'h2c;
    localparam logic [7:0] DEC_SEL_RESET = 8'h04;
    localparam logic [7:0] FILT_CTL_RESET = 8'h00;
    // ==========================================================
    // Field layout
    localparam int IRQ_MASK_BIT = 4;
    localparam int SRC_LSB = 2;
    localparam int FINAL_SEL_BIT = 7;
    localparam int DEPTH_LSB = 3;
    localparam logic [7:0] DEC_SEL_WMASK = 8'h1c;
    localparam logic [7:0] FILT_CTL_WMASK = 8'hf8;
    localparam logic [3:0] DEPTH_BYPASS = 4'h0;
    localparam logic [3:0] DEPTH_ONE = 4'h1;
    localparam logic [3:0] DEPTH_THREE = 4'h3;
    localparam logic [3:0] DEPTH_SEVEN = 4'h7;
    // ==========================================================
    // Types
    typedef enum logic [1:0] {
        SRC_FINAL = 2'h0,
        SRC_COMB2 = 2'h1,
        SRC_DECHOP = 2'h2,
        SRC_COMB = 2'h3
    } src_type;
    typedef struct packed {
        logic [15:0] fir;
        logic [15:0] moving_average;
        logic [15:0] comb2;
        logic [15:0] dechop;
        logic [15:0] comb;
    } stage_words_type;
endpackage : vfilt_pkg

//--- hw/voltage_channel_filter_output_ctl.sv
`timescale 1ns/1ps
module voltage_channel_filter_output_ctl
    import vfilt_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [6:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic otp_lock_in,
    input wire stage_words_type stages_in,
    input wire logic sample_valid_in,
    output logic [7:0] reg_rdata_out,
    output logic reg_rvalid_out,
    output logic fwd_wr_out,
    output logic [6:0] fwd_addr_out,
    output logic [7:0] fwd_wdata_out,
    output logic wr_refused_out,
    output logic [15:0] word_out,
    output logic word_valid_out,
    output logic irq_out,
    output logic moving_average_en_out,
    output logic [2:0] moving_average_depth_out
);
    // ==========================================================
    // Register file
    logic [7:0] dec_sel_r, dec_sel_nxt;
    logic [7:0] filt_ctl_r, filt_ctl_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    logic rvalid_r, rvalid_nxt;
    logic fwd_wr_r, fwd_wr_nxt;
    logic [6:0] fwd_addr_r, fwd_addr_nxt;
    logic [7:0] fwd_wdata_r, fwd_wdata_nxt;
    logic refused_r, refused_nxt;
    logic in_ro, in_test;

    always_comb begin
        in_ro = (reg_addr_in >= RO_LO_ADDR) && (reg_addr_in <= RO_HI_ADDR);
        in_test = (reg_addr_in >= TEST_LO_ADDR) && (reg_addr_in <= TEST_HI_ADDR);
        dec_sel_nxt = dec_sel_r;
        filt_ctl_nxt = filt_ctl_r;
        fwd_wr_nxt = 1'b0;
        fwd_addr_nxt = fwd_addr_r;
        fwd_wdata_nxt = fwd_wdata_r;
        refused_nxt = 1'b0;
        if (reg_wr_in) begin
            // The lock only narrows what is already read-only; it is kept so the
            // test range stays shut even if the read-only window is ever relaxed.
            if (in_ro || (otp_lock_in && in_test)) begin
                refused_nxt = 1'b1;
            end else if (reg_addr_in == DEC_SEL_ADDR) begin
                dec_sel_nxt = reg_wdata_in & DEC_SEL_WMASK;
            end else if (reg_addr_in == FILT_CTL_ADDR) begin
                filt_ctl_nxt = reg_wdata_in & FILT_CTL_WMASK;
            end else begin
                fwd_wr_nxt = 1'b1;
                fwd_addr_nxt = reg_addr_in;
                fwd_wdata_nxt = reg_wdata_in;
            end
        end
        rvalid_nxt = reg_rd_in;
        rdata_nxt = rdata_r;
        if (reg_rd_in) begin
            if (reg_addr_in == DEC_SEL_ADDR) begin
                rdata_nxt = dec_sel_r & DEC_SEL_WMASK;
            end else if (reg_addr_in == FILT_CTL_ADDR) begin
                rdata_nxt = filt_ctl_r & FILT_CTL_WMASK;
            end else begin
                rdata_nxt = 8'h00;
            end
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            dec_sel_r <= DEC_SEL_RESET;
            filt_ctl_r <= FILT_CTL_RESET;
            rdata_r <= 8'h00;
            rvalid_r <= 1'b0;
            fwd_wr_r <= 1'b0;
            fwd_addr_r <= 7'h00;
            fwd_wdata_r <= 8'h00;
            refused_r <= 1'b0;
        end else begin
            dec_sel_r <= dec_sel_nxt;
            filt_ctl_r <= filt_ctl_nxt;
            rdata_r <= rdata_nxt;
            rvalid_r <= rvalid_nxt;
            fwd_wr_r <= fwd_wr_nxt;
            fwd_addr_r <= fwd_addr_nxt;
            fwd_wdata_r <= fwd_wdata_nxt;
            refused_r <= refused_nxt;
        end
    end

    assign reg_rdata_out = rdata_r;
    assign reg_rvalid_out = rvalid_r;
    assign fwd_wr_out = fwd_wr_r;
    assign fwd_addr_out = fwd_addr_r;
    assign fwd_wdata_out = fwd_wdata_r;
    assign wr_refused_out = refused_r;

    // ==========================================================
    // Output stage
    src_type src;
    logic moving_average_sel;
    logic [3:0] depth_code;
    logic [15:0] word_r, word_nxt;
    logic valid_r, valid_nxt;
    logic irq_r, irq_nxt;
    logic moving_average_en_r, moving_average_en_nxt;
    logic [2:0] depth_r, depth_nxt;

    always_comb begin
        src = src_type'(dec_sel_r[SRC_LSB +: 2]);
        moving_average_sel = filt_ctl_r[FINAL_SEL_BIT];
        depth_code = filt_ctl_r[DEPTH_LSB +: 4];
        moving_average_en_nxt = moving_average_sel;
        // Undocumented depth codes fall back to bypass rather than guess a count.
        unique case (depth_code)
            DEPTH_ONE: depth_nxt = 3'h1;
            DEPTH_THREE: depth_nxt = 3'h3;
            DEPTH_SEVEN: depth_nxt = 3'h7;
            default: depth_nxt = 3'h0;
        endcase
        word_nxt = word_r;
        if (sample_valid_in) begin
            unique case (src)
                SRC_FINAL: begin
                    word_nxt = moving_average_sel ? stages_in.moving_average : stages_in.fir;
                end
                SRC_COMB2: word_nxt = stages_in.comb2;
                SRC_DECHOP: word_nxt = stages_in.dechop;
                SRC_COMB: word_nxt = stages_in.comb;
            endcase
        end
        valid_nxt = sample_valid_in;
        irq_nxt = sample_valid_in && !dec_sel_r[IRQ_MASK_BIT];
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            word_r <= 16'h0000;
            valid_r <= 1'b0;
            irq_r <= 1'b0;
            moving_average_en_r <= 1'b0;
            depth_r <= 3'h0;
        end else begin
            word_r <= word_nxt;
            valid_r <= valid_nxt;
            irq_r <= irq_nxt;
            moving_average_en_r <= moving_average_en_nxt;
            depth_r <= depth_nxt;
        end
    end

    assign word_out = word_r;
    assign word_valid_out = valid_r;
    assign irq_out = irq_r;
    assign moving_average_en_out = moving_average_en_r;
    assign moving_average_depth_out = depth_r;

    // ==========================================================
    // Assertions
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    irq_mask_gate_a: assert property (
        sample_valid_in |=> irq_out == !$past(dec_sel_r[IRQ_MASK_BIT]))
        else $error("interrupt does not follow the mask bit");
    irq_needs_data_a: assert property (
        irq_out |-> word_valid_out)
        else $error("interrupt without a data word");
    src_comb2_a: assert property (
        sample_valid_in && dec_sel_r[3:2] == 2'h1 |=> word_out == $past(stages_in.comb2))
        else $error("second comb stage not selected");
    src_final_a: assert property (
        sample_valid_in && dec_sel_r[3:2] == 2'h0 |=>
        word_out == ($past(filt_ctl_r[7]) ? $past(stages_in.moving_average) : $past(stages_in.fir)))
        else $error("final filter source wrong");
    depth_seven_a: assert property (
        filt_ctl_r[6:3] == 4'h7 |=> moving_average_depth_out == 3'h7)
        else $error("averaging depth not seven");
    ro_write_block_a: assert property (
        reg_wr_in && reg_addr_in >= 7'h19 && reg_addr_in <= 7'h2c |=>
        wr_refused_out && !fwd_wr_out && $stable(dec_sel_r) && $stable(filt_ctl_r))
        else $error("write into read-only range took effect");
    lock_block_a: assert property (
        reg_wr_in && otp_lock_in && reg_addr_in >= 7'h1a && reg_addr_in <= 7'h2c |=> !fwd_wr_out)
        else $error("locked test register was written");
    reserved_zero_a: assert property (
        reg_rvalid_out |-> (reg_rdata_out & ~8'hfc) == 8'h00 ##0
        (dec_sel_r & 8'he3) == 8'h00 ##0 (filt_ctl_r & 8'h07) == 8'h00)
        else $error("reserved bit set");
    src_dechop_a: assert property (
        sample_valid_in && dec_sel_r[3:2] == 2'h2 |=> word_out == $past(stages_in.dechop))
        else $error("dechop stage not selected");
    src_comb_a: assert property (
        sample_valid_in && dec_sel_r[3:2] == 2'h3 |=> word_out == $past(stages_in.comb))
        else $error("comb stage not selected");
    final_filter_a: assert property (
        moving_average_en_out == $past(filt_ctl_r[FINAL_SEL_BIT]))
        else $error("final filter flag does not follow its bit");
    depth_bypass_a: assert property (
        filt_ctl_r[6:3] == 4'h0 |=> moving_average_depth_out == 3'h0)
        else $error("averaging not bypassed");
    depth_three_a: assert property (
        filt_ctl_r[6:3] == 4'h3 |=> moving_average_depth_out == 3'h3)
        else $error("averaging depth not three");

    cover_masked_sample_c: cover property (sample_valid_in && dec_sel_r[IRQ_MASK_BIT] ##1 !irq_out);
    cover_average_output_c: cover property (sample_valid_in && src == SRC_FINAL && moving_average_sel);
    cover_dechop_source_c: cover property (sample_valid_in && src == SRC_DECHOP);
    cover_refused_c: cover property (reg_wr_in && in_ro ##1 wr_refused_out);
    cover_read_back_c: cover property (reg_rd_in && reg_addr_in == FILT_CTL_ADDR ##1 reg_rvalid_out);
endmodule : voltage_channel_filter_output_ctl

//--- verif/vfilt_host_model.sv
`timescale 1ns/1ps
// ==========================================
// Host side of the register port
module vfilt_host_model (
    input wire logic clk_in,
    input wire logic [7:0] rdata_in,
    output logic wr_out = 1'b0,
    output logic rd_out = 1'b0,
    output logic [6:0] addr_out = 7'h00,
    output logic [7:0] wdata_out = 8'h00
);
    // The data lines get the inverse after a write, so stale data never looks valid.
    task automatic write_reg(input logic [6:0] a, input logic [7:0] v);
        @(negedge clk_in);
        addr_out = a;
        wdata_out = v;
        wr_out = 1'b1;
        @(negedge clk_in);
        wr_out = 1'b0;
        wdata_out = ~v;
    endtask : write_reg
    task automatic read_reg(input logic [6:0] a, output logic [7:0] v);
        @(negedge clk_in);
        addr_out = a;
        rd_out = 1'b1;
        @(negedge clk_in);
        rd_out = 1'b0;
        v = rdata_in;
    endtask : read_reg
endmodule : vfilt_host_model

//--- verif/voltage_channel_filter_output_ctl_tb_top.sv
`timescale 1ns/1ps
module voltage_channel_filter_output_ctl_tb_top;
    import vfilt_pkg::*;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic lock = 1'b0;
    logic sv = 1'b0;
    stage_words_type st = {16'h1111, 16'h2222, 16'h3333, 16'h4444, 16'h5555};
    logic wr, rd, rv, fw, refd, wv, irq, avg_en;
    logic [6:0] a, fa;
    logic [7:0] wd, rdt, fd, d;
    logic [15:0] word;
    logic [2:0] dep;
    logic [3:0] codes [4] = '{4'h0, 4'h1, 4'h3, 4'h7};
    logic [15:0] exp_src [4] = '{16'h1111, 16'h3333, 16'h4444, 16'h5555};
    int fails = 0;
    int n_tests = 0;
    int cycles = 0;
    always #4 clk_in = ~clk_in;
    vfilt_host_model u_vfilt_host_model (.clk_in(clk_in), .rdata_in(rdt), .wr_out(wr),
        .rd_out(rd), .addr_out(a), .wdata_out(wd));
    voltage_channel_filter_output_ctl u_voltage_channel_filter_output_ctl (.clk_in(clk_in),
        .rst_in(rst_in), .reg_wr_in(wr), .reg_rd_in(rd), .reg_addr_in(a), .reg_wdata_in(wd),
        .otp_lock_in(lock), .stages_in(st), .sample_valid_in(sv), .reg_rdata_out(rdt),
        .reg_rvalid_out(rv), .fwd_wr_out(fw), .fwd_addr_out(fa), .fwd_wdata_out(fd),
        .wr_refused_out(refd), .word_out(word), .word_valid_out(wv), .irq_out(irq),
        .moving_average_en_out(avg_en), .moving_average_depth_out(dep));
    // ==========================================
    // Checking and closing
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : tally_and_finish
    task automatic sample(input logic [15:0] e, input logic ei);
        @(negedge clk_in);
        sv = 1'b1;
        @(negedge clk_in);
        sv = 1'b0;
        chk(16'({wv, irq}), 16'({1'b1, ei}));
        chk(word, e);
    endtask : sample
    // The run needs under a hundred cycles; the ceiling leaves wide margin for a hang.
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 3000) begin
            fails++;
            tally_and_finish();
        end
    end
    // ==========================================
    // Scenarios
    initial begin
        repeat (10) @(negedge clk_in);
        rst_in = 1'b0;
        u_vfilt_host_model.read_reg(DEC_SEL_ADDR, d);
        chk(16'({d, rv}), 16'h0009);
        u_vfilt_host_model.read_reg(FILT_CTL_ADDR, d);
        chk(16'({d, rv}), 16'h0001);
        u_vfilt_host_model.write_reg(FILT_CTL_ADDR, 8'hff);
        u_vfilt_host_model.read_reg(FILT_CTL_ADDR, d);
        chk(16'({d, avg_en, dep}), 16'h0f88);
        // The averaging outputs are registered from the control register, one cycle late.
        for (int i = 0; i < 4; i++) begin
            u_vfilt_host_model.write_reg(FILT_CTL_ADDR, {1'b1, codes[i], 3'h0});
            @(negedge clk_in);
            chk(16'({avg_en, dep}), 16'({1'b1, codes[i][2:0]}));
        end
        u_vfilt_host_model.write_reg(FILT_CTL_ADDR, 8'h00);
        @(negedge clk_in);
        chk(16'(avg_en), 16'h0000);
        u_vfilt_host_model.write_reg(DEC_SEL_ADDR, 8'hff);
        u_vfilt_host_model.read_reg(DEC_SEL_ADDR, d);
        chk(16'(d), 16'h001c);
        sample(16'h5555, 1'b0);
        for (int s = 0; s < 4; s++) begin
            u_vfilt_host_model.write_reg(DEC_SEL_ADDR, 8'(s << 2));
            sample(exp_src[s], 1'b1);
        end
        u_vfilt_host_model.write_reg(FILT_CTL_ADDR, 8'h80);
        u_vfilt_host_model.write_reg(DEC_SEL_ADDR, 8'h00);
        sample(16'h2222, 1'b1);
        u_vfilt_host_model.write_reg(7'h19, 8'h5a);
        chk(16'({refd, fw}), 16'h0002);
        u_vfilt_host_model.write_reg(7'h2c, 8'h5a);
        chk(16'({refd, fw}), 16'h0002);
        lock = 1'b1;
        u_vfilt_host_model.write_reg(7'h1a, 8'h5a);
        chk(16'({refd, fw}), 16'h0002);
        u_vfilt_host_model.write_reg(7'h18, 8'h5a);
        chk(16'({refd, fw, fa}), 16'h0098);
        chk(16'(fd), 16'h005a);
        tally_and_finish();
    end
endmodule : voltage_channel_filter_output_ctl_tb_top
